// ### hdl/ubd_pkg.sv
// Package with offsets, field layouts and reset values of the baud divisor block.
package ubd_pkg;
  localparam logic [2:0] UBD_OFF_DIV_LOW = 3'h0;
  localparam logic [2:0] UBD_OFF_DIV_HIGH = 3'h1;
  localparam logic [2:0] UBD_OFF_LINE_CTRL = 3'h3;
  localparam logic [2:0] UBD_OFF_SCRATCH = 3'h7;
  localparam int UBD_DLAB_BIT = 7;
  localparam int UBD_PRESC_LSB = 3;
  localparam int UBD_PRESC_W = 5;
  localparam int UBD_SAMPLE_W = 4;
  localparam int UBD_OVERSAMPLE = 16;
  localparam logic [7:0] UBD_LCR_RESET = 8'h00;
  localparam logic [7:0] UBD_SCRATCH_RESET = 8'h00;
  localparam logic [15:0] UBD_DIV_RESET = 16'h0001;
  localparam logic [4:0] UBD_PRESC_RESET = 5'h01;
  localparam logic [3:0] UBD_SAMPLE_RESET = 4'h0;
  localparam logic [3:0] UBD_SAMPLE_FAST = 4'h4;
  localparam int UBD_SAMPLE_DEFAULT_DIV = 16;
endpackage : ubd_pkg

// ### hdl/ubd_divider.sv
// Reloadable divider producing a one-cycle enable every div_i clock enables.
`timescale 1ns/100ps
`default_nettype none
module ubd_divider #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Control
  input wire logic restart_i,
  input wire logic en_i,
  input wire logic [WIDTH-1:0] div_i,
  // Output
  output logic tick_o
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] limit;

  // A divisor of zero behaves as one so the tick never stalls.
  assign limit = (div_i == '0) ? WIDTH'(1) : div_i;

  always_ff @(posedge mclk_i) begin
    if (srst_i || restart_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else if (en_i) begin
      if (count >= limit - WIDTH'(1)) begin
        count <= '0;
        tick_o <= 1'b1;
      end else begin
        count <= count + WIDTH'(1);
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule : ubd_divider
`default_nettype wire

// ### hdl/ubd_baud_divisor.sv
// Baud divisor latch, scratch register, prescaler and 16x sample tick generator.
`timescale 1ns/100ps
`default_nettype none
module ubd_baud_divisor
  import ubd_pkg::*;
#(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rhit_o,
  // Extended settings from the indexed control registers
  input wire logic presc_wr_i,
  input wire logic [7:0] presc_data_i,
  input wire logic sample_wr_i,
  input wire logic [3:0] sample_data_i,
  input wire logic presc_enable_i,
  // Outputs to the rest of the UART
  output logic dlab_o,
  output logic [7:0] index_offset_o,
  output logic [4:0] presc_o,
  output logic [3:0] sample_o,
  output logic tick16_o
);
  // Register state.
  logic [7:0] line_control_register;
  logic [7:0] scratch_pad;
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic [4:0] clock_prescaler_register;
  logic [3:0] sample_clock_register;

  // Strobes and ticks.
  logic wr_line_ctrl;
  logic wr_scratch;
  logic wr_div_low;
  logic wr_div_high;
  logic div_write;
  logic presc_tick;
  logic baud_en;
  logic baud_tick;
  logic [DIV_W-1:0] divisor;

  // Write decode. The divisor bytes share their offsets with data and interrupt registers
  // elsewhere in the UART, so they only take a write while the access bit is set.
  assign wr_line_ctrl = wr_i && (addr_i == UBD_OFF_LINE_CTRL);
  assign wr_scratch = wr_i && (addr_i == UBD_OFF_SCRATCH);
  assign wr_div_low = wr_i && dlab_o && (addr_i == UBD_OFF_DIV_LOW);
  assign wr_div_high = wr_i && dlab_o && (addr_i == UBD_OFF_DIV_HIGH);
  assign div_write = wr_div_low || wr_div_high;

  assign dlab_o = line_control_register[UBD_DLAB_BIT];
  assign divisor = DIV_W'({baud_divisor_high, baud_divisor_low});

  // Only the divisor access bit is used here; the rest of the byte is held for readback.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      line_control_register <= UBD_LCR_RESET;
    end else if (wr_line_ctrl) begin
      line_control_register <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      scratch_pad <= UBD_SCRATCH_RESET;
    end else if (wr_scratch) begin
      scratch_pad <= wdata_i;
    end
  end

  assign index_offset_o = scratch_pad;

  // Each byte has its own enable so a write to one never disturbs the other.
  // Software must write both bytes; the tick runs on a half-updated value in between.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      baud_divisor_low <= UBD_DIV_RESET[7:0];
    end else if (wr_div_low) begin
      baud_divisor_low <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      baud_divisor_high <= UBD_DIV_RESET[15:8];
    end else if (wr_div_high) begin
      baud_divisor_high <= wdata_i;
    end
  end

  // The prescaler keeps only its five-bit field; the low bits of the byte are dropped.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      clock_prescaler_register <= UBD_PRESC_RESET;
    end else if (presc_wr_i) begin
      clock_prescaler_register <= presc_data_i[UBD_PRESC_LSB +: UBD_PRESC_W];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sample_clock_register <= UBD_SAMPLE_RESET;
    end else if (sample_wr_i) begin
      sample_clock_register <= sample_data_i;
    end
  end

  assign presc_o = clock_prescaler_register;
  assign sample_o = sample_clock_register;

  // Offsets 2, 4, 5 and 6 belong to other parts of the UART and never answer here.
  always_comb begin
    rhit_o = 1'b0;
    if (rd_i) begin
      case (addr_i)
        UBD_OFF_DIV_LOW: begin
          rhit_o = dlab_o;
        end
        UBD_OFF_DIV_HIGH: begin
          rhit_o = dlab_o;
        end
        UBD_OFF_LINE_CTRL: begin
          rhit_o = 1'b1;
        end
        UBD_OFF_SCRATCH: begin
          rhit_o = 1'b1;
        end
        default: begin
          rhit_o = 1'b0;
        end
      endcase
    end
  end

  // Read mux; offsets 0 and 1 answer only while the divisor access bit is set.
  // The data is combinational, so the host must hold address and strobe while it samples.
  always_comb begin
    rdata_o = 8'h00;
    if (rd_i) begin
      case (addr_i)
        UBD_OFF_DIV_LOW: begin
          rdata_o = dlab_o ? baud_divisor_low : 8'h00;
        end
        UBD_OFF_DIV_HIGH: begin
          rdata_o = dlab_o ? baud_divisor_high : 8'h00;
        end
        UBD_OFF_LINE_CTRL: begin
          rdata_o = line_control_register;
        end
        UBD_OFF_SCRATCH: begin
          rdata_o = scratch_pad;
        end
        default: begin
          rdata_o = 8'h00;
        end
      endcase
    end
  end

  // Prescaler stage: when enabled, the reference is divided by the prescaler field.
  ubd_divider #(
    .WIDTH(5)
  ) u_presc (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .restart_i(div_write),
    .en_i(presc_enable_i),
    .div_i(clock_prescaler_register),
    .tick_o(presc_tick)
  );

  // Without the prescaler every reference clock counts toward the divisor.
  assign baud_en = presc_enable_i ? presc_tick : 1'b1;

  // Divisor stage clocked by the prescaler enable or straight by the reference.
  ubd_divider #(
    .WIDTH(DIV_W)
  ) u_baud (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .restart_i(div_write),
    .en_i(baud_en),
    .div_i(divisor),
    .tick_o(baud_tick)
  );

  // Each divided tick is one sixteenth of a bit, so it is the 16x tick itself.
  // A tick landing in a divisor write cycle still belongs to the old divisor and is dropped.
  // The sample-clock register is only stored and exported; it does not shorten the tick.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tick16_o <= 1'b0;
    end else begin
      tick16_o <= baud_tick && !div_write;
    end
  end
endmodule : ubd_baud_divisor
`default_nettype wire

// ### verification/ubd_baud_divisor_props.sv
// Checker for the baud divisor block ports.
`timescale 1ns/100ps
`default_nettype none
module ubd_props (
  // Watched ports
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [2:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic presc_wr_i,
  input wire logic [7:0] presc_data_i,
  input wire logic sample_wr_i,
  input wire logic [3:0] sample_data_i,
  input wire logic presc_enable_i,
  input wire logic dlab_o,
  input wire logic [7:0] index_offset_o,
  input wire logic [4:0] presc_o,
  input wire logic [3:0] sample_o,
  input wire logic tick16_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic [15:0] dv;
  always_ff @(posedge mclk_i) begin
    if (srst_i) dv <= 16'h0001;
    else if (wr_i && dlab_o && addr_i == 3'h0) dv[7:0] <= wdata_i;
    else if (wr_i && dlab_o && addr_i == 3'h1) dv[15:8] <= wdata_i;
  end
  sequence s_wr(a); wr_i && dlab_o && addr_i == a; endsequence
  sequence s_rd(a); rd_i && dlab_o && addr_i == a; endsequence
  a_scratch_holds: assert property (
    wr_i && addr_i == 3'h7 |=> index_offset_o == $past(wdata_i)) else $error("scratch lost");
  a_low_byte: assert property (
    s_wr(3'h0) ##1 s_rd(3'h0) |-> rdata_o == $past(wdata_i)) else $error("low byte wrong");
  a_high_byte: assert property (
    s_wr(3'h1) ##1 s_rd(3'h1) |-> rdata_o == $past(wdata_i)) else $error("high byte wrong");
  a_latch_gated: assert property (
    rd_i && !dlab_o && addr_i inside {3'h0, 3'h1} |-> rdata_o == 8'h00) else $error("not gated");
  // A tick right after a write may still come from the old count.
  a_tick_period: assert property (disable iff (srst_i || wr_i || presc_enable_i)
    tick16_o && !$past(wr_i) && dv == 16'h0004 && !presc_enable_i |=> !tick16_o [*3] ##1 tick16_o)
    else $error("tick period wrong");
  a_div_restart: assert property (
    s_wr(3'h0) ##0 (dv[15:8] == 8'h00 && wdata_i == 8'h04 && !presc_enable_i)
    |=> ##1 !tick16_o [*2] ##[1:4] tick16_o) else $error("no restart");
  a_presc_load: assert property (
    presc_wr_i |=> presc_o == $past(presc_data_i[7:3])) else $error("prescaler wrong");
  a_sample_load: assert property (
    sample_wr_i |=> sample_o == $past(sample_data_i)) else $error("sample clock wrong");
endmodule : ubd_props
bind ubd_baud_divisor ubd_props u_props (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .presc_wr_i(presc_wr_i),
  .presc_data_i(presc_data_i), .sample_wr_i(sample_wr_i), .sample_data_i(sample_data_i),
  .presc_enable_i(presc_enable_i), .dlab_o(dlab_o), .index_offset_o(index_offset_o),
  .presc_o(presc_o), .sample_o(sample_o), .tick16_o(tick16_o));
`default_nettype wire

// ### verification/tb_ubd_baud_divisor.sv
// Self-checking bench for the baud divisor block.
`timescale 1ns/100ps
`default_nettype none
module tb_ubd_baud_divisor
  import ubd_pkg::*;
;
  logic mclk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rhit_o, dlab_o, tick16_o;
  logic presc_wr_i = 1'b0, sample_wr_i = 1'b0, presc_enable_i = 1'b0, dl_set = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, presc_data_i = 8'h00, rdata_o, index_offset_o;
  logic [3:0] sample_data_i = 4'h0, sample_o;
  logic [4:0] presc_o;
  logic [7:0] exp_q[$];
  logic [15:0] dvs[5] = '{16'h0060, 16'h0008, 16'h0022, 16'h0011, 16'h0004};
  int num_errors = 0, checks_done = 0, seed = 94663, n;
  always #12.5 mclk_i = ~mclk_i;
  ubd_baud_divisor dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rhit_o(rhit_o),
    .presc_wr_i(presc_wr_i), .presc_data_i(presc_data_i), .sample_wr_i(sample_wr_i),
    .sample_data_i(sample_data_i), .presc_enable_i(presc_enable_i), .dlab_o(dlab_o),
    .index_offset_o(index_offset_o), .presc_o(presc_o), .sample_o(sample_o),
    .tick16_o(tick16_o));
  task automatic check(string nm, logic [7:0] seen, logic [7:0] ex);
    checks_done++;
    if (seen !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check
  task automatic close_out;
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic wait_tick;
    int k;
    k = 0;
    while (tick16_o !== 1'b1 && k < 50) begin
      @(posedge mclk_i) #2;
      k++;
    end
    if (k == 50) begin
      num_errors++;
      close_out();
    end
  endtask : wait_tick
  task automatic wr(logic [2:0] a, logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(posedge mclk_i) #2;
    wr_i = 1'b0;
  endtask : wr
  task automatic rd(logic [2:0] a, logic [7:0] ex);
    addr_i = a;
    rd_i = 1'b1;
    exp_q.push_back(ex);
    @(posedge mclk_i) #2;
    rd_i = 1'b0;
  endtask : rd
  // Read data is combinational, so it is taken at the edge that ends the read.
  always @(posedge mclk_i) begin
    if (rd_i) begin
      check("rdata", rdata_o, exp_q.pop_front());
      check("rhit", {7'h00, rhit_o}, {7'h00, addr_i == 3'h3 || addr_i == 3'h7 || (addr_i <= 3'h1 && dl_set)});
    end
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    #2 srst_i = 1'b0;
    rd(UBD_OFF_DIV_LOW, 8'h00);
    repeat (4) begin
      n = $random(seed);
      wr(UBD_OFF_SCRATCH, n[7:0]);
      rd(UBD_OFF_SCRATCH, n[7:0]);
      check("index", index_offset_o, n[7:0]);
    end
    wr(UBD_OFF_DIV_LOW, 8'h5a);
    wr(UBD_OFF_LINE_CTRL, 8'h80);
    dl_set = 1'b1;
    check("dlab", {7'h00, dlab_o}, 8'h01);
    rd(UBD_OFF_DIV_LOW, 8'h01);
    foreach (dvs[i]) begin
      wr(UBD_OFF_DIV_HIGH, dvs[i][15:8]);
      rd(UBD_OFF_DIV_HIGH, dvs[i][15:8]);
      wr(UBD_OFF_DIV_LOW, dvs[i][7:0]);
      rd(UBD_OFF_DIV_LOW, dvs[i][7:0]);
    end
    wait_tick();
    n = 0;
    repeat (40) begin
      @(posedge mclk_i) #2;
      n += tick16_o;
    end
    check("ticks", n[7:0], 8'h0a);
    foreach (dvs[i]) begin
      presc_data_i = {i[0] ? 5'h01 : 5'h04, 3'h5};
      sample_data_i = UBD_SAMPLE_FAST;
      presc_wr_i = 1'b1;
      sample_wr_i = 1'b1;
      @(posedge mclk_i) #2;
      presc_wr_i = 1'b0;
      sample_wr_i = 1'b0;
      check("presc", 8'(presc_o), i[0] ? 8'h01 : 8'h04);
      check("sample", 8'(sample_o), 8'h04);
    end
    presc_enable_i = 1'b1;
    wait_tick();
    n = 0;
    repeat (64) begin
      @(posedge mclk_i) #2;
      n += tick16_o;
    end
    check("presc_ticks", n[7:0], 8'h04);
    close_out();
  end
endmodule : tb_ubd_baud_divisor
`default_nettype wire
